// file: crs_pkg.sv
// Package: constants for the processor register and status file
package crs_pkg;

  // Register index map for the software port (word index, byte addr = 4 * index)
  localparam logic [4:0] ADDR_PAD_BASE   = 5'h00;  // 0x00..0x0F: scratch-pad registers
  localparam logic [4:0] ADDR_STATUS     = 5'h10;  // Program status word
  localparam logic [4:0] ADDR_MASK       = 5'h11;  // Interrupt mask
  localparam logic [4:0] ADDR_KEY0       = 5'h12;  // Protect key 0
  localparam logic [4:0] ADDR_KEY1       = 5'h13;  // Protect key 1
  localparam logic [4:0] ADDR_AUX        = 5'h14;  // Aux multiplex address (read only)
  localparam logic [4:0] ADDR_CTL_SET    = 5'h15;  // Write ones to set control bits
  localparam logic [4:0] ADDR_CTL_CLR    = 5'h16;  // Write ones to clear control bits
  localparam logic [4:0] ADDR_EVT_STAT   = 5'h17;  // Sticky event status, write one to clear
  localparam logic [4:0] ADDR_EVT_MASK   = 5'h18;  // Event interrupt mask
  localparam logic [4:0] ADDR_ALU        = 5'h19;  // Last arithmetic result (read only)

  // Status word field positions (bit 0 is the MSB in the machine's numbering)
  localparam int PRIO_LSB  = 10;  // priority_level occupies machine bits 0..5
  localparam int COND_LSB  = 8;   // condition_code occupies machine bits 6..7
  localparam int CTL_LSB   = 0;   // general_control occupies machine bits 8..15
  localparam int CTL_RUN   = 7;   // machine bit 8
  localparam int CTL_IEN   = 6;   // machine bit 9
  localparam int CTL_PANEL = 5;   // machine bit 10
  localparam int CTL_PFAIL = 4;   // machine bit 11
  localparam int CTL_RTC   = 3;   // machine bit 12
  localparam int CTL_PROG  = 2;   // machine bit 13
  localparam int CTL_MPERR = 1;   // machine bit 14
  localparam int CTL_USER  = 0;   // machine bit 15

  // Sizes and steps
  localparam int          PAD_DEPTH  = 16;
  localparam int          SLICE_W    = 4;
  localparam int          SLICES     = 4;
  localparam logic [4:0]  PC_STEP1   = 5'h02;  // one-word instruction
  localparam logic [4:0]  PC_STEP2   = 5'h04;  // two-word instruction
  localparam logic [3:0]  PIO_MAX    = 4'h7;   // programmed channel may use 1..7
  localparam logic [3:0]  REG_PC     = 4'h0;
  localparam logic [3:0]  REG_STACK  = 4'hF;

  // Values after reset
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST   = 16'h0000;
  localparam logic [15:0] KEY_RST    = 16'h0000;
  localparam logic [5:0]  EVT_RST    = 6'h00;
  localparam logic [14:0] PC_RST     = 15'h0000;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [2:0]  SYNC_RST   = 3'h0;

  // Arithmetic operations
  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS} crs_alu_type;

endpackage

// file: crs_pad_slice.sv
// Scratch-pad slice: one 16-word by 4-bit random-access module
`timescale 1ns/1ns
module crs_pad_slice
(
  input  wire logic                           core_clk,
  input  wire logic                           writeEn,
  input  wire logic [3:0]                     writeSel,
  input  wire logic [crs_pkg::SLICE_W-1:0]    writeData,
  input  wire logic [3:0]                     readSelA,
  input  wire logic [3:0]                     readSelB,
  output logic      [crs_pkg::SLICE_W-1:0]    readDataA,
  output logic      [crs_pkg::SLICE_W-1:0]    readDataB
);
  import crs_pkg::*;

  logic [SLICE_W-1:0] cells [PAD_DEPTH];

  // No reset on the array: like the original RAM chips, content is undefined at power up
  always_ff @(posedge core_clk)
  begin
    if (writeEn)
      cells[writeSel] <= writeData;
  end

  // Asynchronous read ports
  assign readDataA = cells[readSelA];
  assign readDataB = cells[readSelB];
endmodule

// file: crs_alu.sv
// Arithmetic unit: 16-bit parallel two's complement operations with condition code
`timescale 1ns/1ns
module crs_alu
(
  input  wire crs_pkg::crs_alu_type  op,
  input  wire logic [15:0]           opA,
  input  wire logic [15:0]           opB,
  output logic      [15:0]           result,
  output logic      [1:0]            cond
);
  import crs_pkg::*;

  logic [15:0] sum;
  logic [15:0] diff;

  // All sixteen bits in one parallel step
  assign sum  = opA + opB;
  assign diff = opA - opB;

  always_comb
  begin
    unique case (op)
      ALU_ADD:  result = sum;
      ALU_SUB:  result = diff;
      ALU_AND:  result = opA & opB;
      ALU_OR:   result = opA | opB;
      ALU_XOR:  result = opA ^ opB;
      ALU_PASS: result = opA;
      default:  result = opA;
    endcase
  end

  // Condition: 00 zero, 01 positive, 10 negative (sign is the MSB)
  assign cond = (result == 16'h0000) ? 2'h0 : (result[15] ? 2'h2 : 2'h1);
endmodule

// file: crs_register_file.sv
// Top: processor scratch pad, status word, mask, keys and aux address register
//
// Overview of operation
// - Register 0 is a 15-bit instruction counter
// - Counter advances 2 or 4 per instruction
// - Upper 15 bits address memory words
// - Registers 1..14 are 16-bit general purpose
// - Register 15 is the interrupt stack pointer
// - Four 16x4 slices form sixteen registers
// - Programmed channel selects only registers 1..7
// - Register 0 reserved for multiplex transfers
// - Aux register holds address during multiplex exchange
// - Two-bit condition code updated by some instructions
// - Control bits individually set or cleared
// - Sixteen-bit mask gates interrupt signal lines
// - Optional one or two protect keys
// - Six-bit priority level, 0 to 63
// - Level, condition, control packed in status word
// - Control bit 8 run, bit 9 interrupt enable
// - Arithmetic is 16-bit parallel two's complement
// - Bits 10..15 flag panel, power, clock, program, protect, user
`timescale 1ns/1ns
module crs_register_file
#(
  parameter int KEY_COUNT = 2  // Protect keys fitted: 0, 1 or 2
)
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // Software register port
  input  wire logic [4:0]          regAddr,
  input  wire logic [15:0]         regWrData,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [15:0]         regRdData,
  // Instruction sequencer side
  input  wire logic [15:0]         instrWord,
  input  wire logic                instrDone,
  input  wire logic                instrTwoWord,
  input  wire logic                pioAccess,
  input  wire logic                padWrite,
  input  wire logic [15:0]         padWrData,
  input  wire logic                aluStart,
  input  wire crs_pkg::crs_alu_type aluOp,
  input  wire logic                condUpdate,
  // Multiplex channel side
  input  wire logic                muxExchange,
  input  wire logic [15:0]         muxWrData,
  input  wire logic                muxWrite,
  // Interrupt signal lines and event sources
  input  wire logic [15:0]         irqLines,
  input  wire logic                panelEvent,
  input  wire logic                powerFailEvent,
  input  wire logic                clockEvent,
  input  wire logic                programEvent,
  input  wire logic                protectEvent,
  // Outputs
  output logic      [14:0]         memWordAddr,
  output logic      [15:0]         operandA,
  output logic      [15:0]         operandB,
  output logic      [15:0]         statusWord,
  output logic                     commonIrq,
  output logic                     pioRegError,
  output logic                     irq
);
  import crs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  // Scratch-pad words have no reset: software writes a word before it trusts it
  logic [14:0] instrCounter;
  logic [15:0] padWordA;
  logic [15:0] padWordB;
  logic [5:0]  priorityLevel;
  logic [1:0]  conditionCode;
  logic [7:0]  generalControl;
  logic [15:0] interruptMask;
  logic [15:0] protectKey [2];
  logic [15:0] auxMultiplexAddress;
  logic [15:0] aluResult;
  logic [5:0]  evtStatus;
  logic [5:0]  evtMask;
  logic [2:0]  pinPanel;
  logic [2:0]  pinPower;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction field decode: r1 in bits 4..7, r2 in bits 12..15 (machine numbering)
  wire  [3:0]  fieldR1     = instrWord[11:8];
  wire  [3:0]  fieldR2     = instrWord[3:0];
  // Programmed channel may only reach registers 1..7
  wire         pioBadSel   = pioAccess && (fieldR1 == REG_PC || fieldR1 > PIO_MAX);
  // Register 0 is the counter and belongs to multiplex transfers, never a general target
  wire         seqPadWr    = padWrite && !pioBadSel && fieldR1 != REG_PC;
  wire         swPadSel    = regAddr[4] == 1'b0;
  wire         swPadWr     = regWrite && swPadSel && regAddr[3:0] != REG_PC;
  wire         swPcWr      = regWrite && swPadSel && regAddr[3:0] == REG_PC;
  // Software wins the write port; sequencer writes wait a cycle at system level
  wire         padWrEn     = swPadWr || seqPadWr;
  wire  [3:0]  padWrSel    = swPadWr ? regAddr[3:0] : fieldR1;
  wire  [15:0] padWrWord   = swPadWr ? regWrData : padWrData;
  wire  [3:0]  padRdSelA   = regRead && swPadSel ? regAddr[3:0] : fieldR1;

  ////////////////////////////////////////////////////////////////////////////////
  // Scratch pad built from four 16x4 slices
  // Registers 1..14 general and 15 stack pointer share the same array
  genvar g;
  generate
    for (g = 0; g < SLICES; g++)
    begin : gSlice
      crs_pad_slice uSlice
      (
        .core_clk  (core_clk),
        .writeEn   (padWrEn),
        .writeSel  (padWrSel),
        .writeData (padWrWord[g*SLICE_W +: SLICE_W]),
        .readSelA  (padRdSelA),
        .readSelB  (fieldR2),
        .readDataA (padWordA[g*SLICE_W +: SLICE_W]),
        .readDataB (padWordB[g*SLICE_W +: SLICE_W])
      );
    end
  endgenerate

  // Register 0 reads as the counter, kept as a word address shifted left by one
  wire  [15:0] pcByte      = {instrCounter, 1'b0};
  wire  [15:0] regA        = fieldR1 == REG_PC ? pcByte : padWordA;
  wire  [15:0] regB        = fieldR2 == REG_PC ? pcByte : padWordB;

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit
  logic [15:0] aluOut;
  logic [1:0]  aluCond;
  crs_alu uAlu
  (
    .op     (aluOp),
    .opA    (regA),
    .opB    (regB),
    .result (aluOut),
    .cond   (aluCond)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Counter step: 2 or 4 bytes, i.e. 1 or 2 words in the stored 15-bit form
  wire  [15:0] pcStep      = {11'h000, instrTwoWord ? PC_STEP2 : PC_STEP1};
  wire  [15:0] pcNextByte  = pcByte + pcStep;

  // Counter: software load, else advance only when the instruction has completed
  // A software load wins over a completing instruction in the same cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      instrCounter <= PC_RST;
    else if (swPcWr)
      instrCounter <= regWrData[15:1];
    else if (instrDone)
      instrCounter <= pcNextByte[15:1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Aux address: captures the running instruction address while multiplex runs
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      auxMultiplexAddress <= WORD_RST;
    else if (muxExchange && !instrDone)
      auxMultiplexAddress <= pcByte;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for asynchronous event lines; stage 0 feeds only stage 1
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinPanel <= SYNC_RST;
      pinPower <= SYNC_RST;
    end
    else
    begin
      pinPanel <= {pinPanel[1:0], panelEvent};
      pinPower <= {pinPower[1:0], powerFailEvent};
    end
  end

  // A rise counts once stages 1 and 2 both see the high level
  wire         panelRise   = pinPanel[1] && pinPanel[2] && !evtStatus[0] && !generalControl[CTL_PANEL];
  wire         powerRise   = pinPower[1] && pinPower[2] && !evtStatus[1] && !generalControl[CTL_PFAIL];
  wire  [5:0]  evtSet      = {pioBadSel, protectEvent, programEvent, clockEvent,
                              powerRise, panelRise};

  ////////////////////////////////////////////////////////////////////////////////
  // Control-bit set/clear decode; hardware events set their flag bits
  wire         ctlSetWr    = regWrite && regAddr == ADDR_CTL_SET;
  wire         ctlClrWr    = regWrite && regAddr == ADDR_CTL_CLR;
  wire         statusWr    = regWrite && regAddr == ADDR_STATUS;
  wire  [7:0]  hwFlags     = {2'h0, evtSet[0], evtSet[1], evtSet[2], evtSet[3], evtSet[4], 1'b0};
  wire  [7:0]  ctlAfterSw  = statusWr ? regWrData[CTL_LSB +: 8]
                           : (generalControl | (ctlSetWr ? regWrData[7:0] : 8'h00))
                             & ~(ctlClrWr ? regWrData[7:0] : 8'h00);
  // Hardware set beats a software clear in the same cycle
  wire  [7:0]  next_generalControl = ctlAfterSw | hwFlags;

  // Status word: level, condition and control bits
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      priorityLevel  <= STATUS_RST[PRIO_LSB +: 6];
      conditionCode  <= STATUS_RST[COND_LSB +: 2];
      generalControl <= STATUS_RST[CTL_LSB +: 8];
    end
    else
    begin
      generalControl <= next_generalControl;
      if (statusWr)
      begin
        priorityLevel <= regWrData[PRIO_LSB +: 6];
        conditionCode <= regWrData[COND_LSB +: 2];
      end
      else if (condUpdate)
        conditionCode <= aluCond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mask, keys, event mask and status
  wire         maskWr      = regWrite && regAddr == ADDR_MASK;
  wire         key0Wr      = regWrite && regAddr == ADDR_KEY0 && KEY_COUNT > 0;
  wire         key1Wr      = regWrite && regAddr == ADDR_KEY1 && KEY_COUNT > 1;
  wire         evtClrWr    = regWrite && regAddr == ADDR_EVT_STAT;
  wire         evtMaskWr   = regWrite && regAddr == ADDR_EVT_MASK;
  wire  [5:0]  next_evtStatus = (evtStatus & ~(evtClrWr ? regWrData[5:0] : 6'h00)) | evtSet;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interruptMask <= MASK_RST;
      protectKey[0] <= KEY_RST;
      protectKey[1] <= KEY_RST;
      evtStatus     <= EVT_RST;
      evtMask       <= EVT_RST;
    end
    else
    begin
      if (maskWr)
        interruptMask <= regWrData;
      if (key0Wr)
        protectKey[0] <= regWrData;
      if (key1Wr)
        protectKey[1] <= regWrData;
      if (evtMaskWr)
        evtMask <= regWrData[5:0];
      evtStatus <= next_evtStatus;  // Set wins over clear
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic result latch
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      aluResult <= WORD_RST;
    else if (aluStart)
      aluResult <= aluOut;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero, absent keys read zero
  wire  [15:0] statusPacked = {priorityLevel, conditionCode, generalControl};
  logic [15:0] rdMux;
  always_comb
  begin
    rdMux = 16'h0000;
    if (swPadSel)
      rdMux = regAddr[3:0] == REG_PC ? pcByte : padWordA;
    else
    begin
      unique case (regAddr)
        ADDR_STATUS:   rdMux = statusPacked;
        ADDR_MASK:     rdMux = interruptMask;
        ADDR_KEY0:     rdMux = KEY_COUNT > 0 ? protectKey[0] : 16'h0000;
        ADDR_KEY1:     rdMux = KEY_COUNT > 1 ? protectKey[1] : 16'h0000;
        ADDR_AUX:      rdMux = auxMultiplexAddress;
        ADDR_CTL_SET:  rdMux = {8'h00, generalControl};
        ADDR_CTL_CLR:  rdMux = {8'h00, generalControl};
        ADDR_EVT_STAT: rdMux = {10'h000, evtStatus};
        ADDR_EVT_MASK: rdMux = {10'h000, evtMask};
        ADDR_ALU:      rdMux = aluResult;
        default:       rdMux = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  wire  [15:0] gatedLines  = irqLines & interruptMask;

  // Read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= WORD_RST;
    else
      regRdData <= regRead ? rdMux : WORD_RST;
  end

  // Address and operand latches follow the counter and the instruction fields, except that a software pad read points operand A's pad port at regAddr
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memWordAddr <= PC_RST;
      operandA    <= WORD_RST;
      operandB    <= WORD_RST;
    end
    else
    begin
      // Multiplex owns the address latch while exchanging with muxWrite high
      memWordAddr <= muxExchange && muxWrite ? muxWrData[15:1] : instrCounter;
      operandA    <= regA;
      operandB    <= regB;
    end
  end

  // Status copy and interrupt lines; each comes straight from a flip-flop
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      statusWord  <= STATUS_RST;
      commonIrq   <= 1'b0;
      pioRegError <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      statusWord  <= {priorityLevel, conditionCode, next_generalControl};
      // Common line only when interrupts enabled
      commonIrq   <= (|gatedLines) && generalControl[CTL_IEN];
      pioRegError <= pioBadSel;
      irq         <= |(next_evtStatus & evtMask);
    end
  end
endmodule

// file: crs_register_file_assertions.sv
// Checker: port-level properties of the processor register file
`timescale 1ns/1ns
module crs_register_file_checker
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [4:0]  regAddr,
  input wire logic        regRead,
  input wire logic        regWrite,
  input wire logic [15:0] regRdData,
  input wire logic [15:0] instrWord,
  input wire logic        instrDone,
  input wire logic        instrTwoWord,
  input wire logic        pioAccess,
  input wire logic        muxExchange,
  input wire logic        muxWrite,
  input wire logic [15:0] muxWrData,
  input wire logic [15:0] irqLines,
  input wire logic        clockEvent,
  input wire logic        protectEvent,
  input wire logic [14:0] memWordAddr,
  input wire logic [15:0] statusWord,
  input wire logic        commonIrq,
  input wire logic        pioRegError
);
  import crs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Read data stands one cycle only, so a stale word never leaks into later reads
  a_read_idle: assert property (!regRead |=> regRdData == 16'h0000)
    else $error("read data not cleared");
  a_unmapped_zero: assert property (regRead && regAddr > ADDR_ALU |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  // Counter steps seen through the word address; mux drive excluded
  a_step_one: assert property (instrDone && !instrTwoWord && !regWrite && !muxWrite ##1 !muxWrite
    |=> memWordAddr == $past(memWordAddr) + 15'h0001)
    else $error("one-word step wrong");
  a_step_two: assert property (instrDone && instrTwoWord && !regWrite && !muxWrite ##1 !muxWrite
    |=> memWordAddr == $past(memWordAddr) + 15'h0002)
    else $error("two-word step wrong");
  a_mux_route: assert property (muxExchange && muxWrite
    |=> memWordAddr == $past(muxWrData[15:1]))
    else $error("mux address not routed");
  // Programmed channel may only name registers 1..7
  a_pio_bad: assert property (pioAccess && (instrWord[11:8] == 4'h0 || instrWord[11:8] > PIO_MAX)
    |=> pioRegError)
    else $error("bad channel register not flagged");
  a_pio_good: assert property (!pioAccess |=> !pioRegError)
    else $error("channel error without access");
  // Event flags show in the status word at the next edge, even against a clear
  a_rtc_flag: assert property (clockEvent |-> ##1 statusWord[CTL_RTC])
    else $error("clock flag missing");
  a_mperr_flag: assert property (protectEvent |-> ##1 statusWord[CTL_MPERR])
    else $error("protect flag missing");
  a_irq_quiet: assert property (irqLines == 16'h0000 |=> !commonIrq)
    else $error("common interrupt without line");
endmodule
bind crs_register_file crs_register_file_checker u_crs_register_file_checker (.*);

// file: crs_register_file_tb.sv
// Testbench: register port, sequencer and event checks of the register file
`timescale 1ns/1ns
module crs_register_file_tb;
  import crs_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] instrWord = 16'h0000;
  logic [15:0] padWrData = 16'h0000;
  logic [15:0] muxWrData = 16'h0000;
  logic [15:0] irqLines = 16'h0000;
  logic        regWrite = 1'b0, regRead = 1'b0, instrDone = 1'b0, instrTwoWord = 1'b0;
  logic        pioAccess = 1'b0, padWrite = 1'b0, aluStart = 1'b0, condUpdate = 1'b0;
  logic        muxExchange = 1'b0, muxWrite = 1'b0, panelEvent = 1'b0, powerFailEvent = 1'b0;
  logic        clockEvent = 1'b0, programEvent = 1'b0, protectEvent = 1'b0;
  crs_alu_type aluOp = ALU_ADD;
  logic [15:0] regRdData, operandA, operandB, statusWord;
  logic [14:0] memWordAddr;
  logic        commonIrq, pioRegError, irq;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  // Operation table: instruction word, operation, result, condition
  logic [15:0] aluW [6] = '{16'h0305, 16'h0303, 16'h0303, 16'h0305, 16'h0305, 16'h0305};
  crs_alu_type aluO [6] = '{ALU_ADD, ALU_SUB, ALU_OR, ALU_AND, ALU_XOR, ALU_PASS};
  logic [15:0] aluR [6] = '{16'h9234, 16'h0000, 16'h1234, 16'h0000, 16'h9234, 16'h1234};
  logic [1:0]  aluC [6] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1};

  crs_register_file #(.KEY_COUNT(2)) u_crs_register_file (.*);

  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Single-cycle strobes; read data is sampled in the one cycle it stands
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task automatic step(input logic two);
    @(posedge core_clk);
    instrDone <= 1'b1;
    instrTwoWord <= two;
    @(posedge core_clk);
    instrDone <= 1'b0;
    wt(2);
  endtask
  task automatic pulse(input logic [2:0] s);
    @(posedge core_clk);
    {protectEvent, programEvent, clockEvent} <= s;
    @(posedge core_clk);
    {protectEvent, programEvent, clockEvent} <= 3'h0;
    wt(2);
  endtask
  task automatic alu(input logic [15:0] w, input crs_alu_type op, input logic [15:0] r,
                     input logic [1:0] c);
    @(posedge core_clk);
    instrWord <= w;
    wt(2);
    @(posedge core_clk);
    aluOp <= op;
    {aluStart, condUpdate} <= 2'h3;
    @(posedge core_clk);
    {aluStart, condUpdate} <= 2'h0;
    rd(ADDR_ALU, r);
    chk({14'h0000, statusWord[9:8]}, {14'h0000, c});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    wt(1);
    chk(statusWord, STATUS_RST);
    rd(ADDR_MASK, MASK_RST);
    rd(ADDR_KEY1, KEY_RST);
    for (int i = 1; i < 16; i++)
      wr(5'(i), 16'hA500 + 16'(i));
    for (int i = 1; i < 16; i++)
      rd(5'(i), 16'hA500 + 16'(i));
    wr(ADDR_KEY0, 16'h1357);
    wr(ADDR_KEY1, 16'h2468);
    rd(ADDR_KEY0, 16'h1357);
    rd(ADDR_KEY1, 16'h2468);
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    wr(ADDR_PAD_BASE, 16'h0100);
    rd(ADDR_PAD_BASE, 16'h0100);
    step(1'b0);
    rd(ADDR_PAD_BASE, 16'h0102);
    chk({1'b0, memWordAddr}, 16'h0081);
    step(1'b1);
    rd(ADDR_PAD_BASE, 16'h0106);
    chk({1'b0, memWordAddr}, 16'h0083);
    @(posedge core_clk);
    {muxExchange, muxWrite} <= 2'h3;
    muxWrData <= 16'h4444;
    @(posedge core_clk);
    muxWrite <= 1'b0;
    #1 chk({1'b0, memWordAddr}, 16'h2222);
    muxExchange <= 1'b0;
    rd(ADDR_AUX, 16'h0106);
    wr(ADDR_STATUS, 16'hFC00);
    wr(ADDR_CTL_SET, 16'h00C1);
    rd(ADDR_STATUS, 16'hFCC1);
    wr(ADDR_CTL_CLR, 16'h0080);
    rd(ADDR_STATUS, 16'hFC41);
    chk(statusWord, 16'hFC41);
    // Mask gates each line onto the common request
    wr(ADDR_MASK, 16'h0008);
    irqLines <= 16'h0004;
    wt(2);
    chk({15'h0000, commonIrq}, 16'h0000);
    irqLines <= 16'h0008;
    wt(2);
    chk({15'h0000, commonIrq}, 16'h0001);
    wr(ADDR_CTL_CLR, 16'h0040);
    wt(2);
    chk({15'h0000, commonIrq}, 16'h0000);
    // Sticky events: masked one raises irq, write-one clears it
    wr(ADDR_EVT_MASK, 16'h0004);
    pulse(3'h1);
    chk({15'h0000, irq}, 16'h0001);
    rd(ADDR_EVT_STAT, 16'h0004);
    wr(ADDR_EVT_STAT, 16'h0004);
    wt(1);
    chk({15'h0000, irq}, 16'h0000);
    pulse(3'h2);
    pulse(3'h4);
    {panelEvent, powerFailEvent} <= 2'h3;
    wt(6);
    {panelEvent, powerFailEvent} <= 2'h0;
    wt(2);
    chk({15'h0000, irq}, 16'h0000);
    rd(ADDR_EVT_STAT, 16'h001B);
    chk(statusWord, 16'hFC3F);
    // Channel register range
    instrWord <= 16'h0800;
    pioAccess <= 1'b1;
    wt(2);
    chk({15'h0000, pioRegError}, 16'h0001);
    instrWord <= 16'h0700;
    wt(2);
    chk({15'h0000, pioRegError}, 16'h0000);
    pioAccess <= 1'b0;
    // Sequencer writes: register 0 must stay untouched
    @(posedge core_clk);
    instrWord <= 16'h0305;
    padWrite <= 1'b1;
    padWrData <= 16'h1234;
    @(posedge core_clk);
    instrWord <= 16'h0005;
    padWrData <= 16'hDEAD;
    @(posedge core_clk);
    padWrite <= 1'b0;
    rd(ADDR_PAD_BASE, 16'h0106);
    rd(5'h03, 16'h1234);
    wr(5'h05, 16'h8000);
    instrWord <= 16'h0305;
    wt(2);
    chk(operandA, 16'h1234);
    chk(operandB, 16'h8000);
    for (int i = 0; i < 6; i++)
      alu(aluW[i], aluO[i], aluR[i], aluC[i]);
    finish_test();
  end
endmodule
